/* File: design/ppr_map.svh */
// ppr_map.svh: register offsets, reset values and timing figures
// assumes: included by the package and the regulator, 50 MHz clock
`ifndef PPR_MAP_SVH
`define PPR_MAP_SVH
// register indexes, byte address is four times the index
`define PPR_IDX_START     5'h00
`define PPR_IDX_POLARITY  5'h01
`define PPR_IDX_SP_SEL    5'h02
`define PPR_IDX_FB_SEL    5'h03
`define PPR_IDX_TARGET    5'h04
`define PPR_IDX_HI_ALARM  5'h05
`define PPR_IDX_LO_ALARM  5'h06
`define PPR_IDX_PBAND     5'h07
`define PPR_IDX_ITIME     5'h08
`define PPR_IDX_DTIME     5'h09
`define PPR_IDX_STEP      5'h0A
`define PPR_IDX_SB_FREQ   5'h0B
`define PPR_IDX_SB_DUR    5'h0C
`define PPR_IDX_WAKE      5'h0D
`define PPR_IDX_SPAN      5'h0E
`define PPR_IDX_DIGITS    5'h0F
`define PPR_IDX_DECIMALS  5'h10
`define PPR_IDX_STATUS    5'h11
`define PPR_IDX_FREQ      5'h12
`define PPR_IDX_DISPLAY   5'h13
`define PPR_NUM_CFG       17
// reset values of the settings
`define PPR_RST_HI_ALARM  16'h0064
`define PPR_RST_PBAND     16'h03E8
`define PPR_RST_ITIME     16'h0003
`define PPR_RST_STEP      16'h000A
`define PPR_RST_SB_DUR    16'h0064
`define PPR_RST_SPAN      16'h03E8
`define PPR_RST_DIGITS    16'h0004
`define PPR_RST_DECIMALS  16'h0001
// scale figures: percent in 0.01 steps, full scale 100 percent
`define PPR_FULL_SCALE    10000
`define PPR_FREQ_MAX      12000
// update period and clock rate
`define PPR_UPDATE_US     10000
`define PPR_CLK_MHZ       50
// axi response codes
`define PPR_RESP_OKAY     2'h0
`define PPR_RESP_SLVERR   2'h2
`endif

/* File: design/ppr_pkg.sv */
// ppr_pkg: state types of the process regulator
// assumes: ppr_map.svh sits on the include path
`include "ppr_map.svh"
package ppr_pkg;
    // standby sequence, one-hot
    typedef enum logic [1:0] {
        PPR_RUN   = 2'b01,
        PPR_SLEEP = 2'b10
    } ppr_mode_e;

    // whole state of the regulator
    typedef struct packed {
        logic [`PPR_NUM_CFG-1:0][15:0] cfg;
        logic                          aw_ok;
        logic [4:0]                    aw_idx;
        logic                          w_ok;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          rvalid;
        logic [1:0]                    rresp;
        logic [31:0]                   rdata;
        logic                          ext_a;
        logic                          ext_b;
        logic [23:0]                   tick_cnt;
        logic                          tick;
        logic signed [17:0]            err1;
        logic signed [17:0]            err2;
        logic [15:0]                   freq;
        logic [19:0]                   sb_cnt;
        ppr_mode_e                     mode;
        logic                          hi;
        logic                          lo;
        logic [16:0]                   disp;
        logic                          disp_on;
    } ppr_state_s;
endpackage

/* File: design/ppr_regulator.sv */
// ppr_regulator: closed-loop process regulator with axi4-lite registers
// assumes: analog inputs arrive already digitised on clk_sys, in 0.01 %
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "ppr_map.svh"

module ppr_regulator #(
    parameter int unsigned UPDATE_CYCLES = `PPR_UPDATE_US * `PPR_CLK_MHZ
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic [13:0] voltage_analog_input,
    input  wire logic [13:0] current_analog_input,
    input  wire logic        pid_ext_enable,
    output logic [15:0]      freq_out,
    output logic             high_alarm,
    output logic             low_alarm,
    output logic             standby,
    output logic [16:0]      display_value,
    output logic             display_on
);
    localparam logic [23:0] TICK_LAST = 24'(UPDATE_CYCLES - 1);

    ppr_pkg::ppr_state_s s;       // registered state
    ppr_pkg::ppr_state_s next_s;  // next state

    // settings as named views
    logic [15:0] start_m, pol, sp_sel, fb_sel;
    logic [15:0] band, ti, td, step, sbf, sbd, wake;
    logic [15:0] span, digits, decs;
    assign start_m = s.cfg[`PPR_IDX_START];
    assign pol     = s.cfg[`PPR_IDX_POLARITY];
    assign sp_sel  = s.cfg[`PPR_IDX_SP_SEL];
    assign fb_sel  = s.cfg[`PPR_IDX_FB_SEL];
    assign band    = s.cfg[`PPR_IDX_PBAND];
    assign ti      = s.cfg[`PPR_IDX_ITIME];
    assign td      = s.cfg[`PPR_IDX_DTIME];
    assign step    = s.cfg[`PPR_IDX_STEP];
    assign sbf     = s.cfg[`PPR_IDX_SB_FREQ];
    assign sbd     = s.cfg[`PPR_IDX_SB_DUR];
    assign wake    = s.cfg[`PPR_IDX_WAKE];
    assign span    = s.cfg[`PPR_IDX_SPAN];
    assign digits  = s.cfg[`PPR_IDX_DIGITS];
    assign decs    = s.cfg[`PPR_IDX_DECIMALS];

    // loop quantities
    logic [15:0]        sp, fb;       // set point, feedback
    logic               fb_ok;        // feedback source valid
    logic               active;       // regulator enabled
    logic               apply;        // increment applied now
    logic signed [17:0] err;          // signed error
    logic signed [39:0] raw;          // unclamped increment
    logic signed [39:0] dlt;          // clamped increment
    logic signed [39:0] lim;          // step limit
    logic [31:0]        wake_lvl;     // wake-up level
    logic [19:0]        sb_limit;     // standby duration in ticks

    // power of ten for the decimal shift
    function automatic logic [15:0] pow10(input logic [15:0] n);
        case (n)
            16'h0000: pow10 = 16'h0001;
            16'h0001: pow10 = 16'h000A;
            16'h0002: pow10 = 16'h0064;
            16'h0003: pow10 = 16'h03E8;
            default:  pow10 = 16'h2710;
        endcase
    endfunction

    // source selection and error
    always_comb begin
        case (sp_sel)
            16'h0000: sp = s.cfg[`PPR_IDX_TARGET];
            16'h0001: sp = {2'h0, voltage_analog_input};
            16'h0002: sp = {2'h0, current_analog_input};
            default:  sp = 16'h0000;
        endcase
        fb_ok = 1'b1;
        case (fb_sel)
            16'h0000: fb = {2'h0, voltage_analog_input};
            16'h0001: fb = {2'h0, current_analog_input};
            default: begin
                fb    = 16'h0000;
                fb_ok = 1'b0;
            end
        endcase
        // enable by start mode
        case (start_m)
            16'h0001: active = fb_ok;
            16'h0002: active = fb_ok && s.ext_b;
            default:  active = 1'b0;
        endcase
        // negative mode: set point minus feedback
        err = 18'($signed({2'h0, sp}) - $signed({2'h0, fb}));
        if (pol == 16'h0001) begin
            err = -err;
        end
    end

    // incremental pid step and clamp
    always_comb begin
        logic signed [39:0] e0, e1, e2, pt, it, dt, bnd;
        e0  = 40'(err);
        e1  = 40'(s.err1);
        e2  = 40'(s.err2);
        bnd = (band == 16'h0000) ? 40'sd1 : 40'($signed({1'b0, band}));
        pt  = e0 - e1;
        // integral over 10 ms ticks, time in 0.1 s
        it  = (ti == 16'h0000) ? 40'sd0
              : e0 / 40'($signed({1'b0, ti} * 17'd10));
        // derivative time in 0.01 s, one tick per unit
        dt  = 40'($signed({1'b0, td})) * (e0 - 2 * e1 + e2);
        raw = ((pt + it + dt) * 40'sd1000) / bnd;
        lim = 40'($signed({1'b0, step}));
        if (raw > lim) begin
            dlt = lim;
        end else if (raw < -lim) begin
            dlt = -lim;
        end else begin
            dlt = raw;
        end
    end

    assign apply    = s.tick && active && (s.mode == ppr_pkg::PPR_RUN);
    assign wake_lvl = (32'(sp) * 32'(wake)) / 32'd1000;
    assign sb_limit = 20'(sbd) * 20'd10;

    // next state
    always_comb begin
        logic [4:0]         ridx;
        logic signed [39:0] nf;
        logic [39:0]        dv;
        logic [39:0]        cap;
        next_s = s;
        ridx   = s_axi_araddr[6:2];
        nf     = 40'sd0;
        // pin synchroniser, second stage only is read
        next_s.ext_a = pid_ext_enable;
        next_s.ext_b = s.ext_a;
        // 10 ms update tick
        next_s.tick = 1'b0;
        if (s.tick_cnt == TICK_LAST) begin
            next_s.tick_cnt = 24'h000000;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 24'h000001;
        end
        // alarms in whole percent
        next_s.hi = 32'(fb) > (32'(s.cfg[`PPR_IDX_HI_ALARM]) * 32'd100);
        next_s.lo = 32'(fb) < (32'(s.cfg[`PPR_IDX_LO_ALARM]) * 32'd100);
        // display scaling
        dv  = (40'(span) * 40'(fb) * 40'(pow10(decs))) / 40'(`PPR_FULL_SCALE);
        cap = 40'(pow10(digits)) - 40'd1;
        if (digits >= 16'h0005) begin
            cap = 40'd99999;
        end
        next_s.disp    = 17'((dv > cap) ? cap : dv);
        next_s.disp_on = (digits != 16'h0000);
        // regulator and standby sequence
        unique case (s.mode)
            ppr_pkg::PPR_RUN: begin
                if (apply) begin
                    nf = 40'($signed({1'b0, s.freq})) + dlt;
                    if (nf < 40'sd0) begin
                        nf = 40'sd0;
                    end else if (nf > 40'sd`PPR_FREQ_MAX) begin
                        nf = 40'sd`PPR_FREQ_MAX;
                    end
                    next_s.freq = 16'(nf);
                    next_s.err1 = err;
                    next_s.err2 = s.err1;
                    if (s.freq < sbf) begin
                        next_s.sb_cnt = s.sb_cnt + 20'h00001;
                    end else begin
                        next_s.sb_cnt = 20'h00000;
                    end
                    if (s.sb_cnt > sb_limit) begin
                        next_s.mode   = ppr_pkg::PPR_SLEEP;
                        next_s.freq   = 16'h0000;
                        next_s.sb_cnt = 20'h00000;
                    end
                end else if (!active) begin
                    // detached loop forgets its history
                    next_s.err1   = 18'sd0;
                    next_s.err2   = 18'sd0;
                    next_s.sb_cnt = 20'h00000;
                end
            end
            ppr_pkg::PPR_SLEEP: begin
                next_s.freq = 16'h0000;
                if (32'(fb) < wake_lvl) begin
                    next_s.mode = ppr_pkg::PPR_RUN;
                    next_s.err1 = 18'sd0;
                    next_s.err2 = 18'sd0;
                end
            end
        endcase
        // write channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_ok  = 1'b1;
            next_s.aw_idx = s_axi_awaddr[6:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_ok   = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        // write commit once both are held
        if (s.aw_ok && s.w_ok) begin
            next_s.aw_ok  = 1'b0;
            next_s.w_ok   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `PPR_RESP_SLVERR;
            if (32'(s.aw_idx) < `PPR_NUM_CFG) begin
                next_s.bresp = `PPR_RESP_OKAY;
                if (s.w_strb[0]) begin
                    next_s.cfg[s.aw_idx][7:0] = s.w_data[7:0];
                end
                if (s.w_strb[1]) begin
                    next_s.cfg[s.aw_idx][15:8] = s.w_data[15:8];
                end
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // read answer one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `PPR_RESP_OKAY;
            next_s.rdata  = 32'h00000000;
            if (32'(ridx) < `PPR_NUM_CFG) begin
                next_s.rdata = {16'h0000, s.cfg[ridx]};
            end else if (ridx == `PPR_IDX_STATUS) begin
                next_s.rdata = {27'h0, active, s.disp_on, s.mode == ppr_pkg::PPR_SLEEP, s.lo, s.hi};
            end else if (ridx == `PPR_IDX_FREQ) begin
                next_s.rdata = {16'h0000, s.freq};
            end else if (ridx == `PPR_IDX_DISPLAY) begin
                next_s.rdata = {15'h0000, s.disp};
            end else begin
                next_s.rresp = `PPR_RESP_SLVERR;
            end
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    // state register, constants only under reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s      <= '0;
            s.mode <= ppr_pkg::PPR_RUN;
            s.cfg[`PPR_IDX_HI_ALARM] <= `PPR_RST_HI_ALARM;
            s.cfg[`PPR_IDX_PBAND]    <= `PPR_RST_PBAND;
            s.cfg[`PPR_IDX_ITIME]    <= `PPR_RST_ITIME;
            s.cfg[`PPR_IDX_STEP]     <= `PPR_RST_STEP;
            s.cfg[`PPR_IDX_SB_DUR]   <= `PPR_RST_SB_DUR;
            s.cfg[`PPR_IDX_SPAN]     <= `PPR_RST_SPAN;
            s.cfg[`PPR_IDX_DIGITS]   <= `PPR_RST_DIGITS;
            s.cfg[`PPR_IDX_DECIMALS] <= `PPR_RST_DECIMALS;
        end else begin
            s <= next_s;
        end
    end

    // bus handshakes and outputs
    assign s_axi_awready = !s.aw_ok && !s.bvalid;
    assign s_axi_wready  = !s.w_ok && !s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign freq_out      = s.freq;
    assign high_alarm    = s.hi;
    assign low_alarm     = s.lo;
    assign standby       = (s.mode == ppr_pkg::PPR_SLEEP);
    assign display_value = s.disp;
    assign display_on    = s.disp_on;

    // checks
    sequence s_enter_sleep;
        s.mode == ppr_pkg::PPR_RUN ##1 s.mode == ppr_pkg::PPR_SLEEP;
    endsequence
    sequence s_tick_gap;
        !s.tick [*8];
    endsequence

    property p_mode_off;
        @(posedge clk_sys) disable iff (!rst_n) (start_m == 16'h0000) |-> !active;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("loop on while off");
    property p_tick_gap;
        @(posedge clk_sys) disable iff (!rst_n) s.tick |=> s_tick_gap;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    property p_clamp;
        @(posedge clk_sys) disable iff (!rst_n)
            apply && s.freq > step && s.freq < 16'd11000 && s.sb_cnt <= sb_limit |=>
            (s.freq <= $past(s.freq) + $past(step)) && (s.freq + $past(step) >= $past(s.freq));
    endproperty
    a_clamp: assert property (p_clamp) else $error("step above limit");
    property p_hi;
        @(posedge clk_sys) disable iff (!rst_n)
            (32'(fb) > 32'(s.cfg[`PPR_IDX_HI_ALARM]) * 32'd100) ##1 $stable(fb) |-> high_alarm;
    endproperty
    a_hi: assert property (p_hi) else $error("high alarm missing");
    property p_lo;
        @(posedge clk_sys) disable iff (!rst_n)
            (32'(fb) < 32'(s.cfg[`PPR_IDX_LO_ALARM]) * 32'd100) ##1 $stable(fb) |-> low_alarm;
    endproperty
    a_lo: assert property (p_lo) else $error("low alarm missing");
    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
            !active && s.mode == ppr_pkg::PPR_RUN |=> $stable(s.freq);
    endproperty
    a_hold: assert property (p_hold) else $error("freq moved while off");
    property p_sleep_stop;
        @(posedge clk_sys) disable iff (!rst_n) s_enter_sleep |-> freq_out == 16'h0000;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("output on in standby");
    property p_wake;
        @(posedge clk_sys) disable iff (!rst_n)
            standby && 32'(fb) < wake_lvl |=> !standby;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake-up");
    property p_digits;
        @(posedge clk_sys) disable iff (!rst_n) digits == 16'h0000 |=> !display_on;
    endproperty
    a_digits: assert property (p_digits) else $error("display not hidden");
    property p_neg;
        @(posedge clk_sys) disable iff (!rst_n)
            apply && pol == 16'h0000 && fb > sp && s.err1 == err && s.err2 == err
            && s.freq > step |=> s.freq <= $past(s.freq);
    endproperty
    a_neg: assert property (p_neg) else $error("wrong direction");
endmodule

/* File: sim/ppr_sensor_model.sv */
// ppr_sensor_model: process transmitters and enable pin beside the regulator
// assumes: levels chosen by the bench, one clock domain
`timescale 1ns/1ps
module ppr_sensor_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [13:0] v_set,
    input  wire logic [13:0] c_set,
    input  wire logic        en_set,
    output logic [13:0]      voltage_analog_input,
    output logic [13:0]      current_analog_input,
    output logic             pid_ext_enable
);
    // transmitter outputs settle one clock after a new level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            voltage_analog_input <= 14'h0000;
            current_analog_input <= 14'h0000;
            pid_ext_enable       <= 1'b0;
        end else begin
            voltage_analog_input <= v_set;
            current_analog_input <= c_set;
            pid_ext_enable       <= en_set;
        end
    end
endmodule

/* File: sim/process_pid_frequency_regulator_tb.sv */
// process_pid_frequency_regulator_tb: register bus, alarms, display, loop
// assumes: ppr_regulator and ppr_sensor_model compiled before this file
`timescale 1ns/1ps
module process_pid_frequency_regulator_tb;
    localparam int UPD = 50;      // shortened update period
    logic        clk_sys, rst_n;
    logic        awv, wv, bre, arv, rre, es;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat, rd;
    logic        awr, wr_r, bv, arr, rv, hi, lo, sb, don, ext;
    logic [1:0]  br, rr, rsp;
    logic [15:0] freq;
    logic [16:0] disp;
    logic [13:0] vs, cs, va, ca;
    int          err_count, tests_run, seed, mf, e;
    int          rst_tab [17] = '{0, 0, 0, 0, 0, 100, 0, 1000, 3, 0, 10, 0, 100, 0, 1000, 4, 1};

    ppr_regulator #(.UPDATE_CYCLES(UPD)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .voltage_analog_input(va), .current_analog_input(ca), .pid_ext_enable(ext),
        .freq_out(freq), .high_alarm(hi), .low_alarm(lo), .standby(sb),
        .display_value(disp), .display_on(don));

    ppr_sensor_model sens (
        .clk_sys(clk_sys), .rst_n(rst_n), .v_set(vs), .c_set(cs), .en_set(es),
        .voltage_analog_input(va), .current_analog_input(ca), .pid_ext_enable(ext));

    // free running 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // verdict and end of run
    task test_done;
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // one comparison against the reference
    task chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask

    // bus write: address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ga, gw, ok;
        ga = 0;
        gw = 0;
        @(posedge clk_sys);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(negedge clk_sys);
            ok = bv; rsp = br;
            if (awr) ga = 1;
            if (wr_r) gw = 1;
            @(posedge clk_sys);
            if (ga) awv <= 0;
            if (gw) wv <= 0;
        end while (!(ga && gw && ok));
        bre <= 0;
    endtask

    // bus read: arvalid dropped once taken, rready held until rvalid is seen
    task rdr(input logic [7:0] a);
        logic ok, ga;
        ga = 0;
        @(posedge clk_sys);
        ara <= a; arv <= 1; rre <= 1;
        do begin
            @(negedge clk_sys);
            ok = rv; rdat = rd; rsp = rr;
            if (arr) ga = 1;
            @(posedge clk_sys);
            if (ga) arv <= 0;
        end while (!ok);
        rre <= 0;
    endtask

    // new transmitter levels, then settle
    task lv(input int v, input int c);
        @(posedge clk_sys);
        vs <= 14'(v); cs <= 14'(c);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // wait for the next frequency update and follow it in the model
    task tk(input int dlt);
        logic [15:0] f0;
        int n;
        @(negedge clk_sys);
        f0 = freq;
        n = 0;
        while (freq === f0 && n < UPD + 10) begin
            @(negedge clk_sys);
            n++;
        end
        mf += dlt;
        chk(32'(freq), 32'(mf));
    endtask

    // bounded wait for the standby flag
    task wsb(input logic w, input int lim);
        int n;
        n = 0;
        while (sb !== w && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // watchdog well beyond the expected run
    initial begin
        #1000000;
        err_count++;
        test_done();
    end

    // main sequence
    initial begin
        clk_sys = 0; rst_n = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; es = 0;
        awa = 0; ara = 0; wd = 0; vs = 0; cs = 0; err_count = 0; tests_run = 0; seed = 12260; mf = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1;
        for (int i = 0; i < 17; i++) begin
            rdr(8'(i * 4));
            chk(rdat, rst_tab[i]);
        end
        rdr(8'h50);
        chk(32'(rsp), 32'h2);
        wr(8'h48, 32'h1);
        chk(32'(rsp), 32'h2);
        e = $unsigned($random(seed)) % 10001;
        wr(8'h10, e);
        rdr(8'h10);
        chk(rdat, e);
        wr(8'h10, 32'h1388);
        wr(8'h14, 32'h32);
        wr(8'h18, 32'h1E);
        lv(6000, 2000);
        chk(32'({hi, lo}), 32'h2);
        wr(8'h0C, 32'h1);
        lv(6000, 2000);
        chk(32'({hi, lo}), 32'h1);
        wr(8'h0C, 32'h0);
        lv(5000, 8000);
        chk(32'({hi, lo}), 32'h0);
        wr(8'h38, 32'hC8);
        // decimals 0..2, the last one hits the four digit cap
        for (int d = 0; d < 3; d++) begin
            wr(8'h40, d);
            lv(5000, 8000);
            e = 200 * 5000 * (10 ** d) / 10000;
            if (e > 9999) e = 9999;
            chk(32'(disp), e);
            chk(32'(don), 32'h1);
        end
        wr(8'h3C, 32'h0);
        lv(3000, 8000);
        chk(32'(don), 32'h0);
        wr(8'h00, 32'h1);
        repeat (3) tk(10);
        wr(8'h04, 32'h1);
        repeat (2) tk(-10);
        wr(8'h04, 32'h0);
        wr(8'h28, 32'h5);
        tk(5);
        // set point from the current input, then from the voltage input
        wr(8'h08, 32'h2);
        tk(5);
        wr(8'h08, 32'h1);
        tk(-5);
        tk(0);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h0);
        tk(0);
        wr(8'h00, 32'h2);
        tk(0);
        @(posedge clk_sys);
        es <= 1;
        tk(5);
        // feedback above the set point in negative mode lowers the frequency
        lv(7000, 8000);
        repeat (3) tk(-5);
        wr(8'h2C, 32'h2710);
        wr(8'h30, 32'h1);
        wsb(1'b1, 900);
        chk(32'(sb), 32'h1);
        chk(32'(freq), 32'h0);
        rdr(8'h44);
        chk(rdat, 32'h15);
        rdr(8'h48);
        chk(rdat, 32'h0);
        lv(4000, 8000);
        wr(8'h34, 32'h2BC);
        repeat (2 * UPD) @(negedge clk_sys);
        chk(32'(sb), 32'h1);
        lv(3000, 8000);
        wsb(1'b0, 2 * UPD);
        chk(32'(sb), 32'h0);
        test_done();
    end
endmodule
